// [rtl/asw_pkg.sv]
// constants shared by the converter scan and watchdog control block
`default_nettype none
package asw_pkg;
	// control word indices; each word sits at four times its index on the apb port
	localparam logic [7:0] IDX_CTRL_ONE  = 8'hfc;
	localparam logic [7:0] IDX_CTRL_TWO  = 8'hfd;
	localparam logic [11:0] ADDR_CTRL_ONE = {2'b00, IDX_CTRL_ONE, 2'b00};
	localparam logic [11:0] ADDR_CTRL_TWO = {2'b00, IDX_CTRL_TWO, 2'b00};
	localparam logic [11:0] ADDR_IRQ_CTRL = 12'h400;
	localparam logic [11:0] ADDR_CMP_RES  = 12'h404;
	localparam logic [11:0] ADDR_THR_BASE = 12'h410;
	localparam logic [11:0] ADDR_DATA_BASE = 12'h500;
	// control one fields
	localparam int CH_FIRST_LSB = 4;
	localparam int WATCH_PAIR_LSB = 0;
	// control two fields
	localparam int DIV_LSB     = 5;
	localparam int REPEAT_BIT  = 4;
	localparam int GO_BIT      = 3;
	localparam int PIN_EN_BIT  = 2;
	localparam int TMR_EN_BIT  = 1;
	localparam int BIAS_BIT    = 0;
	// interrupt control fields
	localparam int WATCH_FLAG_BIT = 6;
	localparam int EOC_FLAG_BIT   = 5;
	localparam int WATCH_MASK_BIT = 4;
	localparam int EOC_MASK_BIT   = 3;
	localparam int LEVEL_LSB      = 0;
	// compare result flag positions, top four bits
	localparam int CMP_A_UP_BIT = 7;
	localparam int CMP_A_LO_BIT = 6;
	localparam int CMP_B_UP_BIT = 5;
	localparam int CMP_B_LO_BIT = 4;
	// reset values
	localparam logic [7:0] CTRL_ONE_RST = 8'h00;
	localparam logic [7:0] CTRL_TWO_RST = 8'h00;
	localparam logic [7:0] IRQ_CTRL_RST = 8'h00;
	// timing, in analog clock units per divider step
	localparam int SAMPLE_UNITS = 8;
	localparam int CONV_UNITS   = 28;
	localparam int PRE_DIV      = 2;
	localparam logic [3:0] LAST_CH = 4'hf;
endpackage
`default_nettype wire

// [rtl/asw_ctrl.sv]
// converter scan, trigger, window watchdog and request control
//
// Chosen here: the APB slave port.
`default_nettype none
module asw_ctrl #(
	parameter int RES_W = 10
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        external_trigger_pin,
	input  wire logic        timer_trigger,
	input  wire logic        halt_entry,
	input  wire logic [RES_W-1:0] conv_result,
	output logic      [3:0]  mux_channel,
	output logic             sample_hold,
	output logic             analog_bias_enable,
	output logic             watch_irq,
	output logic             eoc_irq,
	output logic      [2:0]  irq_level
);
	// the result split and the window compare are written for ten bits
	if (RES_W != 10) begin : g_res_w_check
		$error("asw_ctrl serves only 10-bit results");
	end
	// unit counter is six bits and the sample phase must be the shorter one
	if (asw_pkg::CONV_UNITS > 64 || asw_pkg::SAMPLE_UNITS >= asw_pkg::CONV_UNITS) begin : g_unit_check
		$error("asw_ctrl unit counts do not fit the six-bit counter");
	end

	typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} asw_state_e;

	typedef struct packed {
		logic [7:0]  ctrl_one;
		logic [7:0]  ctrl_two;
		logic [7:0]  irq_ctrl;
		logic [7:0]  cmp_res;
		logic [3:0][9:0] thr;      // a upper, a lower, b upper, b lower
		logic [15:0][9:0] data;
		asw_state_e  state;
		logic [3:0]  chan;
		logic [2:0]  pre_cnt;
		logic        half;
		logic [5:0]  unit_cnt;
		logic        pin_q;
		logic        tmr_q;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        watch_irq;
		logic        eoc_irq;
		logic        sample_hold;
	} asw_s;

	asw_s s_q, s_d;

	// divider value of zero is taken as one so the counter never stalls
	function automatic logic [2:0] div_val(input logic [7:0] c2);
		div_val = (c2[asw_pkg::DIV_LSB +: 3] == 3'h0) ? 3'h1 : c2[asw_pkg::DIV_LSB +: 3];
	endfunction

	// prescaler wraps after div value periods of pclk divided by two
	function automatic logic pre_wrap(input logic [2:0] cnt, input logic [7:0] c2);
		pre_wrap = (cnt >= div_val(c2) - 3'h1);
	endfunction

	// field views of the control words
	function automatic logic [3:0] first_chan(input logic [7:0] c1);
		first_chan = c1[asw_pkg::CH_FIRST_LSB +: 4];
	endfunction

	function automatic logic [3:0] watch_pair(input logic [7:0] c1);
		watch_pair = c1[asw_pkg::WATCH_PAIR_LSB +: 4];
	endfunction

	// a phase ends on the tick that completes its last unit
	function automatic logic last_unit(input logic [5:0] cnt, input int units);
		last_unit = (cnt == 6'(units - 1));
	endfunction

	// falling edge of a trigger, counted only while its enable is set
	function automatic logic gated_fall(input logic prev, input logic now, input logic en);
		gated_fall = prev & ~now & en;
	endfunction

	// address decode, shared by the write, read and error paths
	function automatic logic hit_ctrl_one(input logic [11:0] a);
		hit_ctrl_one = (a == asw_pkg::ADDR_CTRL_ONE);
	endfunction

	function automatic logic hit_ctrl_two(input logic [11:0] a);
		hit_ctrl_two = (a == asw_pkg::ADDR_CTRL_TWO);
	endfunction

	function automatic logic hit_irq_ctrl(input logic [11:0] a);
		hit_irq_ctrl = (a == asw_pkg::ADDR_IRQ_CTRL);
	endfunction

	function automatic logic hit_cmp_res(input logic [11:0] a);
		hit_cmp_res = (a == asw_pkg::ADDR_CMP_RES);
	endfunction

	function automatic logic hit_thr(input logic [11:0] a);
		hit_thr = (a[11:4] == asw_pkg::ADDR_THR_BASE[11:4]);
	endfunction

	// sixteen channel pairs, high word then low word
	function automatic logic hit_data(input logic [11:0] a);
		hit_data = (a[11:7] == asw_pkg::ADDR_DATA_BASE[11:7]);
	endfunction

	function automatic logic hit_any(input logic [11:0] a);
		hit_any = hit_ctrl_one(a) || hit_ctrl_two(a) || hit_irq_ctrl(a)
			|| hit_cmp_res(a) || hit_thr(a) || hit_data(a);
	endfunction

	// high word of a stored result
	function automatic logic [7:0] res_high(input logic [9:0] r);
		res_high = r[9:2];
	endfunction

	// low word carries the two lsbs at the top, the rest reads zero
	function automatic logic [7:0] res_low(input logic [9:0] r);
		res_low = {r[1:0], 6'h00};
	endfunction

	// pair low channel 15 has no upper neighbour, so only watchdog a runs there
	function automatic logic is_watch_a(input logic [3:0] ch, input logic [3:0] lo);
		is_watch_a = (ch == lo);
	endfunction

	function automatic logic is_watch_b(input logic [3:0] ch, input logic [3:0] lo);
		is_watch_b = (lo != asw_pkg::LAST_CH) && (ch == lo + 4'h1);
	endfunction

	// upper limit itself is already out of range, lower limit itself is not
	function automatic logic over_upper(input logic [9:0] r, input logic [9:0] up);
		over_upper = (r >= up);
	endfunction

	function automatic logic under_lower(input logic [9:0] r, input logic [9:0] lo);
		under_lower = (r < lo);
	endfunction

	// read view of every mapped word; holes read zero
	function automatic logic [31:0] read_word(input asw_s s, input logic [11:0] a);
		read_word = 32'h0;
		if (hit_ctrl_one(a)) begin
			read_word[7:0] = s.ctrl_one;
		end else if (hit_ctrl_two(a)) begin
			read_word[7:0] = s.ctrl_two;
		end else if (hit_irq_ctrl(a)) begin
			read_word[7:0] = s.irq_ctrl;
		end else if (hit_cmp_res(a)) begin
			read_word[7:0] = s.cmp_res;
		end else if (hit_thr(a)) begin
			read_word[9:0] = s.thr[a[3:2]];
		end else if (hit_data(a)) begin
			// high word at even index, low at odd
			if (a[2]) begin
				read_word[7:0] = res_low(s.data[a[6:3]]);
			end else begin
				read_word[7:0] = res_high(s.data[a[6:3]]);
			end
		end
	endfunction

	logic        acc;
	logic        trig_pin_fall;
	logic        trig_tmr_fall;
	logic        tick;
	logic [3:0]  pair_lo;
	logic [9:0]  res;

	always_comb begin
		s_d = s_q;
		acc = psel & penable & ~s_q.pready;
		s_d.pready = acc;
		s_d.pslverr = 1'b0;
		s_d.pin_q = external_trigger_pin;
		s_d.tmr_q = timer_trigger;
		trig_pin_fall = gated_fall(s_q.pin_q, external_trigger_pin,
			s_q.ctrl_two[asw_pkg::PIN_EN_BIT]);
		trig_tmr_fall = gated_fall(s_q.tmr_q, timer_trigger,
			s_q.ctrl_two[asw_pkg::TMR_EN_BIT]);
		tick = 1'b0;
		res = conv_result;
		pair_lo = watch_pair(s_q.ctrl_one);

		// prescaler: divide by two then by div value
		if (s_q.state != ST_IDLE) begin
			s_d.half = ~s_q.half;
			if (s_q.half) begin
				if (pre_wrap(s_q.pre_cnt, s_q.ctrl_two)) begin
					s_d.pre_cnt = 3'h0;
					tick = 1'b1;
				end else begin
					s_d.pre_cnt = s_q.pre_cnt + 3'h1;
				end
			end
		end else begin
			s_d.half = 1'b0;
			s_d.pre_cnt = 3'h0;
		end

		// writes take effect on the edge that raises pready
		if (acc && pwrite) begin
			if (hit_ctrl_one(paddr)) begin
				s_d.ctrl_one = pwdata[7:0];
			end else if (hit_ctrl_two(paddr)) begin
				s_d.ctrl_two = pwdata[7:0];
			end else if (hit_irq_ctrl(paddr)) begin
				s_d.irq_ctrl = pwdata[7:0];
				// a hardware set later in this process still wins over this clear
				if (!pwdata[asw_pkg::WATCH_FLAG_BIT]) begin
					s_d.cmp_res = 8'h00;
				end
			end else if (hit_thr(paddr)) begin
				s_d.thr[paddr[3:2]] = pwdata[9:0];
			end else begin
				// conversion results are read only, writes there are dropped without an error; compare result writes error
				s_d.pslverr = ~hit_data(paddr);
			end
		end else if (acc) begin
			s_d.pslverr = ~hit_any(paddr);
		end

		// triggers gated, ORed, ignored while go set; bias not required
		if (!s_q.ctrl_two[asw_pkg::GO_BIT] && (trig_pin_fall || trig_tmr_fall)) begin
			s_d.ctrl_two[asw_pkg::GO_BIT] = 1'b1;
		end

		// scan sequencer
		case (s_q.state)
			ST_IDLE: begin
				if (s_q.ctrl_two[asw_pkg::GO_BIT]) begin
					s_d.state = ST_SAMPLE;
					s_d.chan = first_chan(s_q.ctrl_one);
					s_d.unit_cnt = 6'h0;
				end
			end
			ST_SAMPLE: begin
				if (tick) begin
					s_d.unit_cnt = s_q.unit_cnt + 6'h1;
					if (last_unit(s_q.unit_cnt, asw_pkg::SAMPLE_UNITS)) s_d.state = ST_CONVERT;
				end
			end
			ST_CONVERT: begin
				if (tick) begin
					s_d.unit_cnt = s_q.unit_cnt + 6'h1;
					if (last_unit(s_q.unit_cnt, asw_pkg::CONV_UNITS)) begin
						s_d.data[s_q.chan] = res;
						// window check on the watched pair
						if (is_watch_a(s_q.chan, pair_lo)) begin
							if (over_upper(res, s_q.thr[0])) begin
								s_d.cmp_res[asw_pkg::CMP_A_UP_BIT] = 1'b1;
								s_d.irq_ctrl[asw_pkg::WATCH_FLAG_BIT] = 1'b1;
							end
							if (under_lower(res, s_q.thr[1])) begin
								s_d.cmp_res[asw_pkg::CMP_A_LO_BIT] = 1'b1;
								s_d.irq_ctrl[asw_pkg::WATCH_FLAG_BIT] = 1'b1;
							end
						end
						if (is_watch_b(s_q.chan, pair_lo)) begin
							if (over_upper(res, s_q.thr[2])) begin
								s_d.cmp_res[asw_pkg::CMP_B_UP_BIT] = 1'b1;
								s_d.irq_ctrl[asw_pkg::WATCH_FLAG_BIT] = 1'b1;
							end
							if (under_lower(res, s_q.thr[3])) begin
								s_d.cmp_res[asw_pkg::CMP_B_LO_BIT] = 1'b1;
								s_d.irq_ctrl[asw_pkg::WATCH_FLAG_BIT] = 1'b1;
							end
						end
						s_d.unit_cnt = 6'h0;
						if (s_q.chan == asw_pkg::LAST_CH) begin
							s_d.irq_ctrl[asw_pkg::EOC_FLAG_BIT] = 1'b1;
							if (!s_q.ctrl_two[asw_pkg::REPEAT_BIT] ||
								!s_d.ctrl_two[asw_pkg::GO_BIT]) begin
								s_d.ctrl_two[asw_pkg::GO_BIT] = 1'b0;
								s_d.state = ST_IDLE;
							end else begin
								s_d.chan = first_chan(s_q.ctrl_one);
								s_d.state = ST_SAMPLE;
							end
						end else begin
							s_d.chan = s_q.chan + 4'h1;
							s_d.state = ST_SAMPLE;
						end
					end
				end
			end
			default: s_d.state = ST_IDLE;
		endcase

		// halt forces bias off
		if (halt_entry) s_d.ctrl_two[asw_pkg::BIAS_BIT] = 1'b0;

		// read data stands only in the pready cycle, zero otherwise
		s_d.prdata = 32'h0;
		if (acc && !pwrite) begin
			s_d.prdata = read_word(s_q, paddr);
		end

		// watchdog first; end-of-conversion stays pending in its flag
		s_d.watch_irq = 1'b0;
		s_d.eoc_irq = 1'b0;
		if (s_q.irq_ctrl[asw_pkg::WATCH_FLAG_BIT] && s_q.irq_ctrl[asw_pkg::WATCH_MASK_BIT]) begin
			s_d.watch_irq = 1'b1;
		end else if (s_q.irq_ctrl[asw_pkg::EOC_FLAG_BIT] && s_q.irq_ctrl[asw_pkg::EOC_MASK_BIT]) begin
			s_d.eoc_irq = 1'b1;
		end
		s_d.sample_hold = (s_d.state == ST_SAMPLE);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			s_q.ctrl_one <= asw_pkg::CTRL_ONE_RST;
			s_q.ctrl_two <= asw_pkg::CTRL_TWO_RST;
			s_q.irq_ctrl <= asw_pkg::IRQ_CTRL_RST;
			s_q.pin_q <= 1'b1;
			s_q.tmr_q <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign mux_channel = s_q.chan;
	assign sample_hold = s_q.sample_hold;
	assign analog_bias_enable = s_q.ctrl_two[asw_pkg::BIAS_BIT];
	assign watch_irq = s_q.watch_irq;
	assign eoc_irq = s_q.eoc_irq;
	assign irq_level = s_q.irq_ctrl[asw_pkg::LEVEL_LSB +: 3];
endmodule
`default_nettype wire

// [dv/asw_conv_model.sv]
// converter core model: result encodes the channel it sampled
`default_nettype none
module asw_conv_model (
	input  wire logic       pclk,
	input  wire logic [3:0] mux_channel,
	input  wire logic       sample_hold,
	output logic      [9:0] conv_result
);
	timeunit 1ns;
	timeprecision 1ps;
	// distinct value per channel exposes a swapped data pair
	always_ff @(posedge pclk) begin
		if (sample_hold) begin
			conv_result <= {mux_channel, ~mux_channel, 2'b10};
		end
	end
endmodule
`default_nettype wire

// [dv/asw_ctrl_checker.sv]
// port assertions for the scan control block
`default_nettype none
module asw_ctrl_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [11:0] paddr,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        halt_entry,
	input wire logic [3:0]  mux_channel,
	input wire logic        sample_hold,
	input wire logic        analog_bias_enable,
	input wire logic        watch_irq,
	input wire logic        eoc_irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_READY_ONE: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	AST_READY_LAT: assert property (psel && penable && !pready |=> pready)
		else $error("pready late");
	AST_ERR_HOLE: assert property (psel && penable && !pready && paddr == 12'hffc
		|=> pslverr) else $error("no error on unmapped address");
	AST_ERR_PAIR: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	AST_SAMPLE_LEN: assert property ($rose(sample_hold) |->
		sample_hold[*8] ##1 sample_hold[*8]) else $error("sampling too short");
	AST_CONV_GAP: assert property ($fell(sample_hold) |-> !sample_hold[*8])
		else $error("conversion too short");
	AST_CHAN_HOLD: assert property (sample_hold && $past(sample_hold) |->
		$stable(mux_channel)) else $error("channel moved while sampling");
	AST_HALT_BIAS: assert property (halt_entry |-> ##[1:2] !analog_bias_enable)
		else $error("bias kept in halt");
	AST_PRIO: assert property (watch_irq |-> !eoc_irq)
		else $error("both requests out");
	cover property ($rose(eoc_irq));
	cover property ($rose(watch_irq));
	cover property (pslverr);
endmodule
bind asw_ctrl asw_ctrl_checker asw_ctrl_checker_inst (.pclk, .presetn, .psel, .penable,
	.paddr, .pready, .pslverr, .halt_entry, .mux_channel, .sample_hold,
	.analog_bias_enable, .watch_irq, .eoc_irq);
`default_nettype wire

// [dv/asw_ctrl_tb_top.sv]
// self-checking bench for the scan control block
`default_nettype none
module asw_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, q;
	logic        pready, pslverr, err, pin = 1, tmr = 1, halt = 0;
	logic        sh, bias, wirq, eirq;
	logic [9:0]  res;
	logic [3:0]  ch;
	logic [2:0]  lvl;
	int          errors = 0, n_tests = 0, cyc = 0, n;
	always #2 pclk = ~pclk;
	asw_ctrl asw_ctrl_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .external_trigger_pin(pin), .timer_trigger(tmr),
		.halt_entry(halt), .conv_result(res), .mux_channel(ch), .sample_hold(sh),
		.analog_bias_enable(bias), .watch_irq(wirq), .eoc_irq(eirq), .irq_level(lvl));
	asw_conv_model asw_conv_model_inst (.pclk, .mux_channel(ch), .sample_hold(sh),
		.conv_result(res));
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// request held until pready is seen high at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(0, a, 0);
		chk(q, e);
	endtask
	task automatic wait_idle();
		do apb(0, asw_pkg::ADDR_CTRL_TWO, 0); while (q[asw_pkg::GO_BIT] === 1'b1);
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			conclude();
		end
	end
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		rd(asw_pkg::ADDR_CTRL_ONE, 0);
		rd(asw_pkg::ADDR_CTRL_TWO, 0);
		rd(asw_pkg::ADDR_CMP_RES, 0);
		rd(12'hffc, 0);
		chk(err, 1);
		apb(1, 12'h540, 32'h3ff);
		chk(err, 0);
		rd(12'h540, 0);
		apb(1, 12'h410, 32'h3ff);
		apb(1, 12'h414, 0);
		apb(1, 12'h418, 32'h3c2);
		apb(1, 12'h41c, 0);
		apb(1, asw_pkg::ADDR_IRQ_CTRL, 32'h1d);
		chk(lvl, 5);
		apb(1, asw_pkg::ADDR_CTRL_ONE, 32'hee);
		apb(1, asw_pkg::ADDR_CTRL_TWO, 32'h21);
		// analog bias settles before the first start
		repeat (2500) @(posedge pclk);
		apb(1, asw_pkg::ADDR_CTRL_TWO, 32'h29);
		wait_idle();
		rd(asw_pkg::ADDR_CTRL_TWO, 32'h21);
		rd(12'h570, 32'he1);
		rd(12'h574, 32'h80);
		rd(12'h578, 32'hf0);
		rd(12'h57c, 32'h80);
		rd(asw_pkg::ADDR_CMP_RES, 32'h20);
		rd(asw_pkg::ADDR_IRQ_CTRL, 32'h7d);
		chk({wirq, eirq}, 2'b10);
		apb(1, asw_pkg::ADDR_IRQ_CTRL, 32'h3d);
		rd(asw_pkg::ADDR_CMP_RES, 0);
		chk({wirq, eirq}, 2'b01);
		apb(1, asw_pkg::ADDR_IRQ_CTRL, 32'h5d);
		chk({wirq, eirq}, 2'b10);
		apb(1, asw_pkg::ADDR_IRQ_CTRL, 32'h1d);
		apb(1, asw_pkg::ADDR_CTRL_ONE, 32'hfe);
		apb(1, asw_pkg::ADDR_CTRL_TWO, 32'h44);
		pin <= 0;
		repeat (3) @(posedge pclk);
		pin <= 1;
		while (sh !== 1'b1) @(posedge pclk);
		for (n = 0; sh === 1'b1; n++) @(posedge pclk);
		chk(n, 32);
		rd(asw_pkg::ADDR_CTRL_TWO, 32'h4c);
		pin <= 0;
		repeat (3) @(posedge pclk);
		pin <= 1;
		wait_idle();
		repeat (8) @(posedge pclk);
		chk(sh, 0);
		rd(asw_pkg::ADDR_CTRL_TWO, 32'h44);
		apb(1, asw_pkg::ADDR_CTRL_TWO, 32'h42);
		pin <= 0;
		repeat (3) @(posedge pclk);
		pin <= 1;
		rd(asw_pkg::ADDR_CTRL_TWO, 32'h42);
		tmr <= 0;
		repeat (3) @(posedge pclk);
		tmr <= 1;
		rd(asw_pkg::ADDR_CTRL_TWO, 32'h4a);
		wait_idle();
		apb(1, asw_pkg::ADDR_CTRL_TWO, 32'h39);
		repeat (2) begin
			while (sh !== 1'b1) @(posedge pclk);
			chk(ch, 15);
			while (sh === 1'b1) @(posedge pclk);
		end
		apb(1, asw_pkg::ADDR_CTRL_TWO, 32'h31);
		wait_idle();
		halt <= 1;
		@(posedge pclk);
		halt <= 0;
		repeat (2) @(posedge pclk);
		chk(bias, 0);
		rd(asw_pkg::ADDR_CTRL_TWO, 32'h30);
		conclude();
	end
endmodule
`default_nettype wire
